// *** hw/processor_system_bus_interface.sv ***
// bus-clock side of the processor external system bus interface
`timescale 1ns/1ns
module processor_system_bus_interface
    import sysbus_pkg::*;
#(
    parameter int IO_BYTES_MAX = IO_MAX_BYTES
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // core request side
    input  wire logic                  req_valid,
    input  wire core_req_t             req,
    input  wire logic [DATA_W-1:0]     req_wdata,
    output logic                       req_ready,
    output logic                       done,
    output logic                       done_error,
    output logic [DATA_W-1:0]          rdata,
    output logic                       rdata_valid,
    // address arbitration
    output logic                       addr_bus_req_n,
    input  wire logic                  addr_bus_grant_n,
    // address start
    output logic                       memory_transfer_start_n,
    output logic                       io_ctrl_transfer_start_n,
    // address transfer
    output logic [ADDR_W-1:0]          addr_out,
    output logic [APAR_W-1:0]          addr_parity_bits,
    output logic                       addr_oe,
    output logic                       addr_parity_err_n,
    // transfer attributes
    output attr_t                      attr,
    // address termination
    input  wire logic                  addr_ack_n,
    input  wire logic                  address_retry_n,
    // data arbitration
    output logic                       data_bus_req_n,
    input  wire logic                  data_bus_grant_n,
    // data transfer
    input  wire logic [DATA_W-1:0]     data_in,
    input  wire logic [DPAR_W-1:0]     data_par_in,
    output logic [DATA_W-1:0]          data_out,
    output logic [DPAR_W-1:0]          data_par_out,
    output logic                       data_oe,
    output logic                       data_parity_err_n,
    // data termination
    input  wire logic                  data_ack_n,
    input  wire logic                  data_retry_n
);
    // ****************************************
    // checks
    // ****************************************
    initial begin
        if (IO_BYTES_MAX < 1 || IO_BYTES_MAX > IO_MAX_BYTES) begin
            $error("io transfer size out of range");
        end
    end

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // control pins: bit0 abg, 1 aack, 2 address_retry_n, 3 dbg, 4 ta, 5 dretry
    localparam int CTL_W = 6;
    logic [CTL_W-1:0] ctl_s1;
    logic [CTL_W-1:0] ctl_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic [DPAR_W-1:0] dpar_s1;
    logic [DPAR_W-1:0] dpar_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1  <= {CTL_W{1'b1}};
            ctl_s2  <= {CTL_W{1'b1}};
            din_s1  <= '0;
            din_s2  <= '0;
            dpar_s1 <= {DPAR_W{1'b1}};
            dpar_s2 <= {DPAR_W{1'b1}};
        end else begin
            ctl_s1  <= {data_retry_n, data_ack_n, data_bus_grant_n,
                        address_retry_n, addr_ack_n, addr_bus_grant_n};
            ctl_s2  <= ctl_s1;
            din_s1  <= data_in;
            din_s2  <= din_s1;
            dpar_s1 <= data_par_in;
            dpar_s2 <= dpar_s1;
        end
    end

    // active-low pins asserted when low
    wire abg_w    = ~ctl_s2[0];
    wire aack_w   = ~ctl_s2[1];
    wire address_retry_n_w  = ~ctl_s2[2];
    wire dbg_w    = ~ctl_s2[3];
    wire ta_w     = ~ctl_s2[4];
    wire dretry_w = ~ctl_s2[5];

    // ****************************************
    // parity
    // ****************************************
    logic [APAR_W-1:0] apar_gen;
    logic [DPAR_W-1:0] dpar_gen;
    logic [DPAR_W-1:0] dpar_chk;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;

    odd_parity #(.LANES(APAR_W)) u_apar (.data(addr_q),  .par(apar_gen));
    odd_parity #(.LANES(DPAR_W)) u_dpar (.data(wdata_q), .par(dpar_gen));
    odd_parity #(.LANES(DPAR_W)) u_dchk (.data(din_s2),  .par(dpar_chk));
    wire rd_par_bad = (dpar_chk != dpar_s2);

    // ****************************************
    // transaction decode
    // ****************************************
    core_req_t cur;
    // bypass accesses forced to single beat; burst only for full sectors
    wire       bypass_w    = req.ci | req.wt;
    op_kind_t  next_kind;
    assign next_kind = (req.kind == OP_BURST && bypass_w) ? OP_SINGLE : req.kind;
    wire       has_data_w  = (cur.kind != OP_ADDR_ONLY);
    wire       is_burst_w  = (cur.kind == OP_BURST);
    wire       is_io_w     = (cur.kind == OP_IO);

    logic [4:0] tt_w;
    assign tt_w = (cur.kind == OP_ADDR_ONLY) ? (cur.write ? TT_KILL : TT_TLB_INV) :
                  is_io_w    ? (cur.write ? TT_IO_STORE : TT_IO_LOAD) :
                  is_burst_w ? (cur.write ? TT_WRITE_BST : TT_READ_BST) :
                               (cur.write ? TT_WRITE : TT_READ);

    attr_t next_attr;
    assign next_attr = '{transfer_type_code: tt_w,
                         size:  is_burst_w ? SIZE_RST : cur.size,
                         burst: is_burst_w,
                         wt:    cur.wt,
                         ci:    cur.ci};

    // ****************************************
    // address tenure
    // ****************************************
    typedef enum logic [2:0] {
        A_IDLE,
        A_REQ,
        A_START,
        A_WAIT,
        A_DONE
    } a_state_t;
    a_state_t a_state;
    a_state_t next_a_state;
    logic     d_busy;
    logic     d_launch;

    always_comb begin
        next_a_state = a_state;
        case (a_state)
            A_IDLE: begin
                if (req_valid) begin
                    next_a_state = A_REQ;
                end
            end
            A_REQ: begin
                if (abg_w) begin
                    next_a_state = A_START;
                end
            end
            A_START: begin
                next_a_state = A_WAIT;
            end
            A_WAIT: begin
                if (address_retry_n_w) begin
                    next_a_state = A_REQ;
                end else if (aack_w) begin
                    next_a_state = A_DONE;
                end
            end
            A_DONE: begin
                // next address may start while data tenure runs on
                if (!has_data_w || !d_busy) begin
                    next_a_state = A_IDLE;
                end
            end
            default: begin
                next_a_state = A_IDLE;
            end
        endcase
    end
    assign d_launch = (a_state == A_DONE) && has_data_w && !d_busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_state <= A_IDLE;
            cur     <= '0;
            wdata_q <= '0;
        end else begin
            a_state <= next_a_state;
            if (a_state == A_IDLE && req_valid) begin
                cur      <= req;
                cur.kind <= next_kind;
                wdata_q  <= req_wdata;
            end
        end
    end
    assign addr_q = cur.addr;

    // pins: strobes one cycle in A_START
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_bus_req_n           <= 1'b1;
            memory_transfer_start_n  <= 1'b1;
            io_ctrl_transfer_start_n <= 1'b1;
            addr_out                 <= '0;
            addr_parity_bits         <= '0;
            addr_oe                  <= 1'b0;
            attr                     <= '0;
            req_ready                <= 1'b0;
        end else begin
            addr_bus_req_n           <= ~(next_a_state == A_REQ);
            memory_transfer_start_n  <= ~(next_a_state == A_START && !is_io_w);
            io_ctrl_transfer_start_n <= ~(next_a_state == A_START && is_io_w);
            addr_oe                  <= (next_a_state == A_START || next_a_state == A_WAIT);
            addr_out                 <= addr_q;
            addr_parity_bits         <= apar_gen;
            attr                     <= next_attr;
            req_ready                <= (next_a_state == A_IDLE);
        end
    end

    // ****************************************
    // data tenure, owned independently of the address bus
    // ****************************************
    typedef enum logic [1:0] {
        D_IDLE,
        D_REQ,
        D_XFER
    } d_state_t;
    d_state_t d_state;
    d_state_t next_d_state;
    logic [1:0] beat;
    logic       d_write;
    logic       d_burst;
    logic       d_err;
    wire        last_beat_w = !d_burst || (beat == 2'(BURST_BEATS - 1));
    wire        beat_ok_w   = (d_state == D_XFER) && ta_w && !dretry_w;
    wire        tenure_end_w = beat_ok_w && last_beat_w;

    always_comb begin
        next_d_state = d_state;
        case (d_state)
            D_IDLE: begin
                if (d_launch) begin
                    next_d_state = D_REQ;
                end
            end
            D_REQ: begin
                if (dbg_w) begin
                    next_d_state = D_XFER;
                end
            end
            D_XFER: begin
                if (tenure_end_w) begin
                    next_d_state = D_IDLE;
                end
            end
            default: begin
                next_d_state = D_IDLE;
            end
        endcase
    end
    assign d_busy = (d_state != D_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d_state <= D_IDLE;
            beat    <= BEAT_RST;
            d_write <= 1'b0;
            d_burst <= 1'b0;
            d_err   <= 1'b0;
        end else begin
            d_state <= next_d_state;
            if (d_launch) begin
                beat    <= BEAT_RST;
                d_write <= cur.write;
                d_burst <= is_burst_w;
                d_err   <= 1'b0;
            end else if (beat_ok_w) begin
                beat  <= beat + 2'h1;
                d_err <= d_err | (!d_write && rd_par_bad);
            end
        end
    end

    // data pins and core results
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_bus_req_n    <= 1'b1;
            data_out          <= '0;
            data_par_out      <= '0;
            data_oe           <= 1'b0;
            data_parity_err_n <= 1'b1;
            addr_parity_err_n <= 1'b1;
            rdata             <= '0;
            rdata_valid       <= 1'b0;
            done              <= 1'b0;
            done_error        <= 1'b0;
        end else begin
            data_bus_req_n    <= ~(next_d_state == D_REQ);
            data_oe           <= (next_d_state == D_XFER) && d_write;
            // one data word reused on every burst beat; core refills are outside this block
            data_out          <= wdata_q;
            data_par_out      <= dpar_gen;
            data_parity_err_n <= ~(beat_ok_w && !d_write && rd_par_bad);
            // address is only driven by this master, so no received address to check
            addr_parity_err_n <= 1'b1;
            rdata             <= din_s2;
            rdata_valid       <= beat_ok_w && !d_write;
            done              <= tenure_end_w ||
                                 (a_state == A_DONE && !has_data_w);
            done_error        <= tenure_end_w && (d_err || (!d_write && rd_par_bad));
        end
    end
    // coherency snooping and io split responses are served by logic beyond this block
endmodule

// *** hw/sysbus_pkg.sv ***
// shared constants and carrier types for the processor system bus interface
package sysbus_pkg;
    // ****************************************
    // widths and sizes
    // ****************************************
    localparam int ADDR_W       = 32;
    localparam int DATA_W       = 64;
    localparam int APAR_W       = ADDR_W / 8;
    localparam int DPAR_W       = DATA_W / 8;
    localparam int BURST_BEATS  = 4;
    localparam int SECTOR_BYTES = 32;
    localparam int IO_MAX_BYTES = 128;

    // ****************************************
    // transfer type codes
    // ****************************************
    localparam logic [4:0] TT_READ      = 5'h0a;
    localparam logic [4:0] TT_WRITE     = 5'h02;
    localparam logic [4:0] TT_READ_BST  = 5'h0e;
    localparam logic [4:0] TT_WRITE_BST = 5'h06;
    localparam logic [4:0] TT_KILL      = 5'h0c;
    localparam logic [4:0] TT_TLB_INV   = 5'h18;
    localparam logic [4:0] TT_IO_LOAD   = 5'h1a;
    localparam logic [4:0] TT_IO_STORE  = 5'h12;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] BEAT_RST = 2'h0;
    localparam logic [2:0] SIZE_RST = 3'h0;

    typedef enum logic [1:0] {
        OP_SINGLE,
        OP_BURST,
        OP_ADDR_ONLY,
        OP_IO
    } op_kind_t;

    // request from the core side
    typedef struct packed {
        op_kind_t           kind;
        logic               write;
        logic               wt;
        logic               ci;
        logic [2:0]         size;
        logic [ADDR_W-1:0]  addr;
    } core_req_t;

    // attributes driven with the address
    typedef struct packed {
        logic [4:0]         transfer_type_code;
        logic [2:0]         size;
        logic               burst;
        logic               wt;
        logic               ci;
    } attr_t;
endpackage

// *** hw/odd_parity.sv ***
// odd parity generator, one bit per byte lane
`timescale 1ns/1ns
module odd_parity
    import sysbus_pkg::*;
#(
    parameter int LANES = 8
) (
    // data in
    input  wire logic [LANES*8-1:0] data,
    // parity out
    output logic      [LANES-1:0]   par
);
    initial begin
        if (LANES < 1) begin
            $error("odd_parity: LANES must be at least one");
        end
    end

    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            assign par[i] = ~(^data[i*8 +: 8]);
        end
    endgenerate
endmodule

// *** sim/processor_system_bus_interface_sva.sv ***
// assertion checker for the processor system bus interface
`timescale 1ns/1ns
module processor_system_bus_interface_sva
    import sysbus_pkg::*;
#(
    parameter int IO_BYTES_MAX = IO_MAX_BYTES
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // address side
    input wire logic              addr_bus_req_n,
    input wire logic              addr_bus_grant_n,
    input wire logic              memory_transfer_start_n,
    input wire logic              io_ctrl_transfer_start_n,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [APAR_W-1:0] addr_parity_bits,
    input wire logic              addr_oe,
    input wire attr_t             attr,
    // data side
    input wire logic              data_bus_grant_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DPAR_W-1:0] data_par_out,
    input wire logic              data_oe,
    input wire logic              data_parity_err_n,
    input wire logic              done,
    input wire logic              done_error
);
    // ****************************************
    // expected odd parity per lane
    // ****************************************
    logic [APAR_W-1:0] apar_exp;
    logic [DPAR_W-1:0] dpar_exp;
    always_comb begin
        for (int i = 0; i < APAR_W; i++) apar_exp[i] = ~^addr_out[i*8 +: 8];
        for (int i = 0; i < DPAR_W; i++) dpar_exp[i] = ~^data_out[i*8 +: 8];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ****************************************
    // properties
    // ****************************************
    sequence s_mem_start; $fell(memory_transfer_start_n); endsequence
    sequence s_io_start; $fell(io_ctrl_transfer_start_n); endsequence
    sequence s_any_start; s_mem_start or s_io_start; endsequence

    property p_mem_strobe; s_mem_start |=> memory_transfer_start_n; endproperty
    property p_one_strobe; s_io_start |-> memory_transfer_start_n; endproperty
    property p_addr_par; addr_oe |-> addr_parity_bits == apar_exp; endproperty
    property p_data_par; data_oe |-> data_par_out == dpar_exp; endproperty
    property p_start_granted; s_any_start |-> addr_oe && !$past(addr_bus_grant_n, 2) && !$past(addr_bus_req_n);
    endproperty
    property p_addr_hold; $rose(addr_oe) |-> addr_oe [*2]; endproperty
    property p_attr_stable; addr_oe && $past(addr_oe) |-> $stable(attr) && $stable(addr_out); endproperty
    property p_bypass_single; (s_mem_start ##0 (attr.wt || attr.ci)) |-> !attr.burst; endproperty
    property p_data_granted; $rose(data_oe) |-> !$past(data_bus_grant_n, 2) || !$past(data_bus_grant_n, 3);
    endproperty
    property p_done_pulse; done |=> !done; endproperty
    property p_err_with_done; done_error |-> done; endproperty
    property p_perr_pulse; !data_parity_err_n |=> data_parity_err_n; endproperty

    a_mem_strobe: assert property (p_mem_strobe) else $error("transfer start held too long");
    a_one_strobe: assert property (p_one_strobe) else $error("both start strobes low");
    a_addr_par: assert property (p_addr_par) else $error("address parity wrong");
    a_data_par: assert property (p_data_par) else $error("data parity wrong");
    a_start_granted: assert property (p_start_granted) else $error("start without grant");
    a_addr_hold: assert property (p_addr_hold) else $error("address dropped early");
    a_attr_stable: assert property (p_attr_stable) else $error("attributes moved");
    a_bypass_single: assert property (p_bypass_single) else $error("bypass access bursted");
    a_data_granted: assert property (p_data_granted) else $error("data driven without grant");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    a_err_with_done: assert property (p_err_with_done) else $error("error without done");
    a_perr_pulse: assert property (p_perr_pulse) else $error("parity error flag stuck");
endmodule

// *** sim/sysbus_far_side.sv ***
// arbiter and memory responder model on the far side of the bus
`timescale 1ns/1ns
module sysbus_far_side
    import sysbus_pkg::*;
#(
    parameter logic [DATA_W-1:0] PAT = 64'h5a3c0f1e2d4b6978
) (
    // clock, reset and scenario controls
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               slow,
    input wire logic               retry_once,
    input wire logic               bad_par,
    // address side
    input wire logic               addr_bus_req_n,
    input wire logic               memory_transfer_start_n,
    input wire logic               io_ctrl_transfer_start_n,
    input wire attr_t              attr,
    output logic                   addr_bus_grant_n,
    output logic                   addr_ack_n,
    output logic                   address_retry_n,
    // data side
    input wire logic               data_bus_req_n,
    output logic                   data_bus_grant_n,
    output logic [DATA_W-1:0]      data_in,
    output logic [DPAR_W-1:0]      data_par_in,
    output logic                   data_ack_n,
    output logic                   data_retry_n,
    output int                     beats
);
    int   awt, ack_wait, dwt, left, nb;
    logic retried, dpend;
    logic [DATA_W-1:0] beat_data;
    logic [DPAR_W-1:0] beat_par;

    assign beat_data = PAT + DATA_W'(beats);
    always_comb begin
        for (int i = 0; i < DPAR_W; i++) beat_par[i] = ~^beat_data[i*8 +: 8];
    end

    always @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            {addr_bus_grant_n, addr_ack_n, address_retry_n} <= 3'h7;
            {data_bus_grant_n, data_ack_n, data_retry_n} <= 3'h7;
            data_in <= PAT;
            data_par_in <= 8'h00;
            {awt, ack_wait, dwt, left, nb, beats} <= {128'h0, 32'd1, 32'd0};
            {retried, dpend} <= 2'h0;
        end else begin
            addr_ack_n <= 1'b1;
            address_retry_n <= 1'b1;
            data_ack_n <= 1'b1;
            // released data lines never hold the last beat
            data_in <= ~data_in;
            data_par_in <= ~data_par_in;
            if (!retry_once) retried <= 1'b0;
            // address grant, slow or prompt; grant follows request only
            if (!addr_bus_req_n) begin
                awt <= awt + 1;
                if (awt >= (slow ? 4 : 1)) addr_bus_grant_n <= 1'b0;
            end else begin
                awt <= 0;
                addr_bus_grant_n <= 1'b1;
            end
            // address phase termination, optionally one retry
            if (!memory_transfer_start_n || !io_ctrl_transfer_start_n) begin
                ack_wait <= slow ? 4 : 2;
                nb <= attr.burst ? BURST_BEATS : 1;
            end else if (ack_wait == 1) begin
                ack_wait <= 0;
                if (retry_once && !retried) begin
                    address_retry_n <= 1'b0;
                    retried <= 1'b1;
                end else begin
                    addr_ack_n <= 1'b0;
                    dpend <= 1'b1;
                end
            end else if (ack_wait > 1) ack_wait <= ack_wait - 1;
            // data grant, then one termination per beat
            if (dpend && left == 0 && !data_bus_req_n) begin
                data_bus_grant_n <= 1'b0;
                dpend <= 1'b0;
                left <= nb;
                dwt <= slow ? 3 : 1;
                beats <= 0;
            end else if (left > 0 && dwt > 0) dwt <= dwt - 1;
            else if (left > 0) begin
                data_ack_n <= 1'b0;
                data_in <= beat_data;
                data_par_in <= beat_par ^ {7'h00, bad_par};
                beats <= beats + 1;
                left <= left - 1;
                if (left == 1) data_bus_grant_n <= 1'b1;
            end
        end
    end
endmodule

// *** sim/processor_system_bus_interface_tb_top.sv ***
// top-level testbench for the processor system bus interface
`timescale 1ns/1ns
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", name, exp, got); end end
module processor_system_bus_interface_tb_top;
    import sysbus_pkg::*;
    localparam logic [DATA_W-1:0] PAT = 64'h5a3c0f1e2d4b6978;
    localparam logic [DATA_W-1:0] WD  = 64'hc3a5_1e0f_9687_4b2d;
    logic clk, rstn, req_valid, req_ready, done, done_error, rdata_valid, addr_bus_req_n, addr_bus_grant_n;
    logic memory_transfer_start_n, io_ctrl_transfer_start_n, addr_oe, addr_parity_err_n, addr_ack_n;
    logic address_retry_n, data_bus_req_n, data_bus_grant_n, data_oe, data_parity_err_n, data_ack_n;
    logic data_retry_n, slow, retry_once, bad_par, saw_oe, dn_err;
    core_req_t         req;
    attr_t             attr, at;
    logic [ADDR_W-1:0] addr_out;
    logic [APAR_W-1:0] addr_parity_bits;
    logic [DPAR_W-1:0] data_par_in, data_par_out;
    logic [DATA_W-1:0] req_wdata, rdata, data_in, data_out, rd, wd;
    int                failures, check_count, beats, ms, is, rv, pe;

    processor_system_bus_interface i_processor_system_bus_interface (.clk, .rstn, .req_valid, .req, .req_wdata,
        .req_ready, .done, .done_error, .rdata, .rdata_valid, .addr_bus_req_n, .addr_bus_grant_n,
        .memory_transfer_start_n, .io_ctrl_transfer_start_n, .addr_out, .addr_parity_bits, .addr_oe,
        .addr_parity_err_n, .attr, .addr_ack_n, .address_retry_n, .data_bus_req_n, .data_bus_grant_n, .data_in,
        .data_par_in, .data_out, .data_par_out, .data_oe, .data_parity_err_n, .data_ack_n, .data_retry_n);
    sysbus_far_side #(.PAT(PAT)) i_sysbus_far_side (.clk, .rstn, .slow, .retry_once, .bad_par, .addr_bus_req_n,
        .memory_transfer_start_n, .io_ctrl_transfer_start_n, .attr, .addr_bus_grant_n, .addr_ack_n,
        .address_retry_n, .data_bus_req_n, .data_bus_grant_n, .data_in, .data_par_in, .data_ack_n,
        .data_retry_n, .beats);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one core request, then watch the bus until done
    task automatic op(input op_kind_t k, input logic w, t, c, input logic [2:0] sz);
        int n;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'b1;
        req = '{k, w, t, c, sz, 32'h0000_1040};
        @(negedge clk);
        req_valid = 1'b0;
        {ms, is, rv, pe, saw_oe, n} = '0;
        while (n < 300) begin
            @(negedge clk);
            n++;
            if (memory_transfer_start_n === 1'b0) {ms, at} = {ms + 1, attr};
            if (io_ctrl_transfer_start_n === 1'b0) {is, at} = {is + 1, attr};
            if (rdata_valid === 1'b1) {rv, rd} = {rv + 1, rdata};
            if (data_oe === 1'b1) {saw_oe, wd} = {1'b1, data_out};
            if (data_parity_err_n === 1'b0) pe++;
            dn_err = done_error;
            if (done === 1'b1) break;
        end
        `CHK("done", 1, n < 300)
    endtask

    task automatic t_burst(input logic w, s);
        slow = s;
        op(OP_BURST, w, 1'b0, 1'b0, 3'h0);
        `CHK("mem starts", 1, ms)
        `CHK("burst", 1'b1, at.burst)
        `CHK("type", w ? TT_WRITE_BST : TT_READ_BST, at.transfer_type_code)
        `CHK("beats", BURST_BEATS, beats)
        `CHK("read beats", w ? 0 : 4, rv)
        if (w) `CHK("wdata", WD, wd) else `CHK("rdata", PAT + 64'h3, rd)
        slow = 1'b0;
    endtask

    task automatic t_single;
        logic [3:0] tbl [4] = '{4'hb, 4'hc, 4'h0, 4'h1};
        for (int i = 0; i < 4; i++) begin
            op(tbl[i][3] ? OP_BURST : OP_SINGLE, tbl[i][0], tbl[i][2], tbl[i][1], 3'(2 * i + 1));
            `CHK("burst", 1'b0, at.burst)
            `CHK("beats", 1, beats)
            `CHK("wt ci", {tbl[i][2], tbl[i][1]}, {at.wt, at.ci})
            `CHK("size", 3'(2 * i + 1), at.size)
            `CHK("type", tbl[i][0] ? TT_WRITE : TT_READ, at.transfer_type_code)
            `CHK("read beats", tbl[i][0] ? 0 : 1, rv)
        end
    endtask

    task automatic t_addr_only;
        for (int w = 0; w < 2; w++) begin
            op(OP_ADDR_ONLY, w[0], 1'b0, 1'b0, 3'h0);
            `CHK("type", w ? TT_KILL : TT_TLB_INV, at.transfer_type_code)
            `CHK("no data", {1'b0, 32'd0}, {saw_oe, rv})
        end
    endtask

    task automatic t_retry;
        retry_once = 1'b1;
        op(OP_BURST, 1'b0, 1'b0, 1'b0, 3'h0);
        `CHK("mem starts", 2, ms)
        `CHK("beats", BURST_BEATS, beats)
        retry_once = 1'b0;
    endtask

    task automatic t_parity;
        bad_par = 1'b1;
        op(OP_SINGLE, 1'b0, 1'b0, 1'b0, 3'h7);
        `CHK("parity flag", 1, pe)
        `CHK("done error", 1'b1, dn_err)
        `CHK("read beats", 1, rv)
        bad_par = 1'b0;
    endtask

    task automatic t_io;
        op(OP_IO, 1'b0, 1'b0, 1'b0, 3'h3);
        `CHK("starts", {32'd1, 32'd0}, {is, ms})
        `CHK("type", TT_IO_LOAD, at.transfer_type_code)
    endtask

    initial begin
        {rstn, req_valid, slow, retry_once, bad_par} = 5'h0;
        req = '0;
        req_wdata = WD;
        repeat (12) @(negedge clk);
        `CHK("idle lines", 5'h19, {addr_bus_req_n, memory_transfer_start_n, addr_oe, data_oe, addr_parity_err_n})
        rstn = 1'b1;
        t_burst(1'b0, 1'b0);
        t_burst(1'b1, 1'b0);
        t_burst(1'b0, 1'b1);
        t_single;
        t_addr_only;
        t_retry;
        t_parity;
        t_io;
        close_out;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule

bind processor_system_bus_interface processor_system_bus_interface_sva #(.IO_BYTES_MAX(IO_BYTES_MAX))
    i_processor_system_bus_interface_sva (.clk, .rstn, .addr_bus_req_n, .addr_bus_grant_n,
    .memory_transfer_start_n, .io_ctrl_transfer_start_n, .addr_out, .addr_parity_bits, .addr_oe, .attr,
    .data_bus_grant_n, .data_out, .data_par_out, .data_oe, .data_parity_err_n, .done, .done_error);
